// *** design/sew_pkg.sv ***
// Constants, carriers and state encodings of the two-wire EEPROM slave.
// Assumes a 200 MHz system clock and a free-running link sample clock.
// What this block does
// - Self-timed program cycle ends within ten milliseconds
// - Busy program cycle: SDA released, address unacknowledged
// - Transfers framed by start/stop; receiver acknowledges bytes
// - Respond only when type code matches
// - Parse type, device address, block, byte
// - Compare straps; block bit from slave address
// - Sixteen-byte page written in one cycle
// - Block of sixteen pages; byte address selects
// - Ignore SCL/SDA pulses shorter than 100 ns
// - Last slave address bit: one read, zero write
// - Protected upper half: data unacknowledged, no program
// - Receiver pulls SDA low on ninth clock
package sew_pkg;
   localparam int MCLK_PERIOD_NS = 5;
   localparam int LINK_PERIOD_NS = 32;
   localparam int NOISE_NS = 100;
   // Least time: round up to whole link cycles
   localparam int FILT_CYC = (NOISE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
   // The standard-supply bound is the tighter one and covers low supply too
   localparam int WR_CYCLE_MS = 10;
   // Slack for the crossings on both ends of the cycle
   localparam int WR_MARGIN_CYC = 64;
   localparam int WR_CYC =
      WR_CYCLE_MS * (1000000 / MCLK_PERIOD_NS) - WR_MARGIN_CYC;
   localparam int TIMER_W = 22;
   localparam int FIFO_DEPTH = 4;
   localparam logic [3:0] BYTE_LAST_BIT = 4'h8;
   localparam logic [3:0] PAGE_STEP = 4'h1;
   localparam logic [3:0] DEV_TYPE_DEF = 4'h5; // Arbitrary value
   localparam logic [2:0] SYNC_RST = 3'h7;
   localparam logic PIN_RST = 1'b1;

   typedef struct packed
   {
      logic first;       // First byte of a new write command
      logic blk;         // Page block
      logic [7:0] addr;  // Byte address inside the block
      logic [7:0] data;
   } sew_prog_word_t;

   localparam int PROG_W = $bits(sew_prog_word_t);

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_DEV = 3'b001,
      ST_WORD = 3'b011,
      ST_DATA = 3'b010,
      ST_SKIP = 3'b110
   } sew_state_t;

   typedef enum logic [1:0]
   {
      PG_IDLE = 2'b00,
      PG_WAIT = 2'b01,
      PG_RUN = 2'b11
   } sew_pg_state_t;
endpackage

// *** design/sew_fifo.sv ***
// Small synchronous FIFO between the byte crossing and the program port.
// Assumes one clock; DEPTH is a power of two.
module sew_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 4
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem_ff [DEPTH];
   logic [AW:0] wr_ptr_ff;
   logic [AW:0] rd_ptr_ff;
   logic full;
   logic empty;

   assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                 (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
   assign empty = (wr_ptr_ff == rd_ptr_ff);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem_ff[rd_ptr_ff[AW-1:0]];

   always_ff @(posedge clk)
   begin
      if (in_valid && !full)
         mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         wr_ptr_ff <= '0;
      else if (in_valid && !full)
         wr_ptr_ff <= wr_ptr_ff + 1'b1;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         rd_ptr_ff <= '0;
      else if (out_ready && !empty)
         rd_ptr_ff <= rd_ptr_ff + 1'b1;
   end
endmodule

// *** design/sew_slave.sv ***
// Two-wire EEPROM slave: pin filter and protocol on the link clock,
// page loading and program-cycle timer on the system clock.
// Assumes SCL and SDA are open-drain lines with pull-ups outside.
module sew_slave #(
   parameter int WR_CYC = sew_pkg::WR_CYC,
   parameter logic [3:0] DEV_TYPE = sew_pkg::DEV_TYPE_DEF // Arbitrary
)
(
   // System clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Link sample clock
   input wire logic link_clk,
   // Two-wire pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Straps and protection
   input wire logic strap_addr_bit_one,
   input wire logic strap_addr_bit_two,
   input wire logic write_protect,
   // Program port
   output sew_pkg::sew_prog_word_t prog_word,
   output logic prog_valid,
   input wire logic prog_ready,
   output logic prog_commit,
   output logic prog_busy
);
   import sew_pkg::*;

   localparam int NPIN = 5;
   localparam logic [2:0] FILT_LAST = 3'(FILT_CYC - 1);
   localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(WR_CYC - 1);

   // ---------------- Link domain: pin conditioning ----------------
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_f;
   logic scl_f;
   logic sda_f;
   logic wp_f;
   logic [1:0] strap_f;

   assign pin_raw = {strap_addr_bit_two, strap_addr_bit_one, write_protect,
                     sda_in, scl_in};
   assign scl_f = pin_f[0];
   assign sda_f = pin_f[1];
   assign wp_f = pin_f[2];
   assign strap_f = pin_f[4:3];

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++)
      begin : g_pin
         logic [2:0] sync_ff;
         logic [2:0] cnt_ff;
         logic stable_ff;

         always_ff @(posedge link_clk or negedge reset_n)
         begin
            if (!reset_n)
               sync_ff <= SYNC_RST;
            else
               sync_ff <= {sync_ff[1:0], pin_raw[gi]};
         end

         // A level must hold for the whole window before it is believed
         always_ff @(posedge link_clk or negedge reset_n)
         begin
            if (!reset_n)
            begin
               cnt_ff <= 3'h0;
               stable_ff <= PIN_RST;
            end
            else if (sync_ff[2] == sync_ff[1] && sync_ff[2] != stable_ff)
            begin
               if (cnt_ff == FILT_LAST)
               begin
                  stable_ff <= sync_ff[2];
                  cnt_ff <= 3'h0;
               end
               else
                  cnt_ff <= cnt_ff + 3'h1;
            end
            else
               cnt_ff <= 3'h0;
         end

         assign pin_f[gi] = stable_ff;
      end
   endgenerate

   logic scl_p_ff;
   logic sda_p_ff;

   always_ff @(posedge link_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         scl_p_ff <= PIN_RST;
         sda_p_ff <= PIN_RST;
      end
      else
      begin
         scl_p_ff <= scl_f;
         sda_p_ff <= sda_f;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;

   assign scl_rise = scl_f && !scl_p_ff;
   assign scl_fall = !scl_f && scl_p_ff;
   assign start_cond = scl_f && scl_p_ff && sda_p_ff && !sda_f;
   assign stop_cond = scl_f && scl_p_ff && !sda_p_ff && sda_f;

   // ---------------- Link domain: crossings back ----------------
   logic req_tgl_ff;
   logic commit_tgl_ff;
   logic [2:0] ack_sync_ff;
   logic [2:0] done_sync_ff;
   logic ack_seen_ff;
   logic done_seen_ff;
   logic req_seen_ff;
   logic done_tgl_ff;

   always_ff @(posedge link_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ack_sync_ff <= 3'h0;
         done_sync_ff <= 3'h0;
      end
      else
      begin
         ack_sync_ff <= {ack_sync_ff[1:0], req_seen_ff};
         done_sync_ff <= {done_sync_ff[1:0], done_tgl_ff};
      end
   end

   always_ff @(posedge link_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ack_seen_ff <= 1'b0;
         done_seen_ff <= 1'b0;
      end
      else
      begin
         if (ack_sync_ff[2] == ack_sync_ff[1])
            ack_seen_ff <= ack_sync_ff[2];
         if (done_sync_ff[2] == done_sync_ff[1])
            done_seen_ff <= done_sync_ff[2];
      end
   end

   logic link_busy;
   logic xfer_free;

   // Busy from the stop until the system side reports the cycle ended
   assign link_busy = (done_seen_ff != commit_tgl_ff);
   assign xfer_free = (ack_seen_ff == req_tgl_ff);

   // ---------------- Link domain: protocol engine ----------------
   sew_state_t st_ff;
   logic [3:0] bitcnt_ff;
   logic [7:0] shreg_ff;
   logic ackph_ff;
   logic sda_oe_ff;
   logic blk_ff;
   logic [7:0] addr_ff;
   logic wrote_ff;
   logic first_ff;
   sew_prog_word_t xfer_word_ff;

   logic byte_done;
   logic dev_match;
   logic protect_hit;
   logic do_ack;
   logic push_byte;

   assign byte_done = scl_fall && bitcnt_ff == BYTE_LAST_BIT && !ackph_ff;
   assign dev_match = shreg_ff[7:4] == DEV_TYPE &&
                      shreg_ff[3:2] == strap_f &&
                      !link_busy;
   assign protect_hit = wp_f && blk_ff;
   always_comb
   begin
      unique case (st_ff)
         ST_DEV: do_ack = dev_match;
         ST_WORD: do_ack = 1'b1;
         ST_DATA: do_ack = !protect_hit && xfer_free;
         ST_IDLE, ST_SKIP: do_ack = 1'b0;
         default: do_ack = 1'b0;
      endcase
   end
   assign push_byte = byte_done && st_ff == ST_DATA && do_ack;

   always_ff @(posedge link_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_ff <= ST_IDLE;
         bitcnt_ff <= 4'h0;
         ackph_ff <= 1'b0;
      end
      else if (start_cond || stop_cond)
      begin
         // Any frame condition drops the byte in flight
         st_ff <= start_cond ? ST_DEV : ST_IDLE;
         bitcnt_ff <= 4'h0;
         ackph_ff <= 1'b0;
      end
      else if (scl_rise && !ackph_ff && bitcnt_ff != BYTE_LAST_BIT &&
               st_ff != ST_IDLE && st_ff != ST_SKIP)
         bitcnt_ff <= bitcnt_ff + 4'h1;
      else if (byte_done)
      begin
         ackph_ff <= 1'b1;
         if (!do_ack)
            st_ff <= ST_SKIP;
         else
         begin
            unique case (st_ff)
               // Fields arrive type, address, block, then byte
               ST_DEV: st_ff <= shreg_ff[0] ? ST_SKIP : ST_WORD;
               ST_WORD: st_ff <= ST_DATA;
               default: st_ff <= st_ff;
            endcase
         end
      end
      else if (scl_fall && ackph_ff)
      begin
         ackph_ff <= 1'b0;
         bitcnt_ff <= 4'h0;
      end
   end

   always_ff @(posedge link_clk or negedge reset_n)
   begin
      if (!reset_n)
         shreg_ff <= 8'h00;
      else if (scl_rise && !ackph_ff && bitcnt_ff != BYTE_LAST_BIT)
         shreg_ff <= {shreg_ff[6:0], sda_f};
   end

   // Acknowledge is driven from the eighth fall to the ninth fall
   always_ff @(posedge link_clk or negedge reset_n)
   begin
      if (!reset_n)
         sda_oe_ff <= 1'b0;
      else if (start_cond || stop_cond || link_busy)
         sda_oe_ff <= 1'b0;
      else if (byte_done)
         sda_oe_ff <= do_ack;
      else if (scl_fall && ackph_ff)
         sda_oe_ff <= 1'b0;
   end

   always_ff @(posedge link_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         blk_ff <= 1'b0;
         addr_ff <= 8'h00;
         first_ff <= 1'b0;
      end
      else if (byte_done && do_ack)
      begin
         if (st_ff == ST_DEV)
            blk_ff <= shreg_ff[1];
         else if (st_ff == ST_WORD)
         begin
            addr_ff <= shreg_ff;
            first_ff <= 1'b1;
         end
         else if (st_ff == ST_DATA)
         begin
            // Wrap inside the page so extra bytes overwrite
            addr_ff[3:0] <= addr_ff[3:0] + PAGE_STEP;
            first_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge link_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         xfer_word_ff <= '0;
         req_tgl_ff <= 1'b0;
      end
      else if (push_byte)
      begin
         xfer_word_ff <= '{first: first_ff, blk: blk_ff, addr: addr_ff,
                           data: shreg_ff};
         req_tgl_ff <= !req_tgl_ff;
      end
   end

   // Only a stop on a byte boundary after a written byte programs
   always_ff @(posedge link_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wrote_ff <= 1'b0;
         commit_tgl_ff <= 1'b0;
      end
      else if (start_cond)
         wrote_ff <= 1'b0;
      else if (stop_cond)
      begin
         wrote_ff <= 1'b0;
         // The stop's own clock high has already counted as one bit
         if (st_ff == ST_DATA && wrote_ff && bitcnt_ff == 4'h1 && !ackph_ff)
            commit_tgl_ff <= !commit_tgl_ff;
      end
      else if (push_byte)
         wrote_ff <= 1'b1;
   end

   assign sda_out = 1'b0;
   assign sda_oe = sda_oe_ff;

   // ---------------- System domain ----------------
   logic [2:0] req_sync_ff;
   logic [2:0] commit_sync_ff;

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         req_sync_ff <= 3'h0;
         commit_sync_ff <= 3'h0;
      end
      else
      begin
         req_sync_ff <= {req_sync_ff[1:0], req_tgl_ff};
         commit_sync_ff <= {commit_sync_ff[1:0], commit_tgl_ff};
      end
   end

   logic push_v;
   logic fifo_in_ready;
   logic commit_new;
   logic commit_seen_ff;

   // The word is held steady by the link side until this toggle returns
   assign push_v = req_sync_ff[2] == req_sync_ff[1] &&
                   req_sync_ff[2] != req_seen_ff;
   assign commit_new = commit_sync_ff[2] == commit_sync_ff[1] &&
                       commit_sync_ff[2] != commit_seen_ff;

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         req_seen_ff <= 1'b0;
      else if (push_v && fifo_in_ready)
         req_seen_ff <= req_sync_ff[2];
   end

   sew_fifo #(
      .W(PROG_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(mclk),
      .reset_n(reset_n),
      .in_valid(push_v),
      .in_ready(fifo_in_ready),
      .in_data(xfer_word_ff),
      .out_valid(prog_valid),
      .out_ready(prog_ready),
      .out_data(prog_word)
   );

   sew_pg_state_t pg_ff;
   logic [TIMER_W-1:0] timer_ff;
   logic prog_commit_ff;
   logic prog_busy_ff;

   // The page is handed over fully before the timed cycle begins
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pg_ff <= PG_IDLE;
         commit_seen_ff <= 1'b0;
         done_tgl_ff <= 1'b0;
         timer_ff <= '0;
         prog_commit_ff <= 1'b0;
      end
      else
      begin
         prog_commit_ff <= 1'b0;
         unique case (pg_ff)
            PG_IDLE:
            begin
               if (commit_new)
               begin
                  commit_seen_ff <= commit_sync_ff[2];
                  pg_ff <= PG_WAIT;
               end
            end
            PG_WAIT:
            begin
               if (!prog_valid && !push_v)
               begin
                  prog_commit_ff <= 1'b1;
                  timer_ff <= '0;
                  pg_ff <= PG_RUN;
               end
            end
            PG_RUN:
            begin
               if (timer_ff == TIMER_LAST)
               begin
                  done_tgl_ff <= commit_seen_ff;
                  pg_ff <= PG_IDLE;
               end
               else
                  timer_ff <= timer_ff + 1'b1;
            end
            default: pg_ff <= PG_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         prog_busy_ff <= 1'b0;
      else
         prog_busy_ff <= (pg_ff != PG_IDLE) || commit_new;
   end

   assign prog_commit = prog_commit_ff;
   assign prog_busy = prog_busy_ff;
endmodule

// *** tb/sew_slave_asserts.sv ***
// Port checker for the two-wire EEPROM slave.
// Assumes WR_CYC matches the instance; bound in below.
module sew_chk #(
   parameter int WR_CYC = 200
)
(
   // Clocks and reset
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic link_clk,
   // Pins and protection
   input wire logic scl_in,
   input wire logic sda_oe,
   input wire logic write_protect,
   // Program port
   input wire sew_pkg::sew_prog_word_t prog_word,
   input wire logic prog_valid,
   input wire logic prog_ready,
   input wire logic prog_commit,
   input wire logic prog_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   import sew_pkg::*;
   logic [31:0] run_ff;
   // Cycles since the last commit
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         run_ff <= 32'h0;
      else if (prog_commit)
         run_ff <= 32'h0;
      else
         run_ff <= run_ff + 32'h1;
   end
   property p_commit_once;
      @(posedge mclk) disable iff (!reset_n) prog_commit |=> !prog_commit;
   endproperty
   a_commit_once: assert property (p_commit_once)
      else $error("commit longer than one cycle");
   property p_commit_busy;
      @(posedge mclk) disable iff (!reset_n) prog_commit |-> prog_busy;
   endproperty
   a_commit_busy: assert property (p_commit_busy)
      else $error("commit without busy");
   property p_commit_drained;
      @(posedge mclk) disable iff (!reset_n) prog_commit |-> !prog_valid;
   endproperty
   a_commit_drained: assert property (p_commit_drained)
      else $error("commit with words pending");
   property p_busy_len;
      @(posedge mclk) disable iff (!reset_n) $fell(prog_busy) |->
         run_ff >= WR_CYC - 4 && run_ff <= WR_CYC + 4;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("program cycle length wrong");
   property p_busy_quiet;
      @(posedge link_clk) disable iff (!reset_n) prog_busy |-> !sda_oe;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet)
      else $error("data line driven while busy");
   property p_word_hold;
      @(posedge mclk) disable iff (!reset_n) prog_valid && !prog_ready
         |=> prog_valid && $stable(prog_word);
   endproperty
   a_word_hold: assert property (p_word_hold)
      else $error("word dropped while stalled");
   property p_ack_scl_low;
      @(posedge link_clk) disable iff (!reset_n) $changed(sda_oe) |-> !scl_in;
   endproperty
   a_ack_scl_low: assert property (p_ack_scl_low)
      else $error("data line moved with clock high");
   property p_protect;
      @(posedge mclk) disable iff (!reset_n)
         prog_valid && write_protect |-> !prog_word.blk;
   endproperty
   a_protect: assert property (p_protect)
      else $error("protected block word issued");
endmodule

bind sew_slave sew_chk #(.WR_CYC(WR_CYC)) u_chk (.mclk(mclk),
   .reset_n(reset_n), .link_clk(link_clk), .scl_in(scl_in),
   .sda_oe(sda_oe), .write_protect(write_protect), .prog_word(prog_word),
   .prog_valid(prog_valid), .prog_ready(prog_ready),
   .prog_commit(prog_commit), .prog_busy(prog_busy));

// *** tb/sew_bus_master.sv ***
// Two-wire bus master model; both lines have pull-ups.
// Assumes tasks are entered on a rising edge of mclk.
module sew_bus_master #(
   parameter int Q = 50
)
(
   // Clock
   input wire logic mclk,
   // Wires
   input wire logic sda_oe,
   input wire logic sda_out,
   output logic scl_line,
   output logic sda_line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic scl_ff = 1'b1;
   logic sda_ff = 1'b1;
   logic glitch = 1'b0;
   assign scl_line = scl_ff;
   // Wired-AND: the device pulls only with its enable; released reads high
   assign sda_line = (sda_ff ^ glitch) & (sda_oe ? sda_out : 1'b1);
   task automatic wait_q();
      repeat (Q) @(posedge mclk);
   endtask
   task automatic start();
      sda_ff <= 1'b1;
      wait_q();
      scl_ff <= 1'b1;
      wait_q();
      sda_ff <= 1'b0;
      wait_q();
      scl_ff <= 1'b0;
      wait_q();
   endtask
   task automatic stop();
      sda_ff <= 1'b0;
      wait_q();
      scl_ff <= 1'b1;
      wait_q();
      sda_ff <= 1'b1;
      wait_q();
   endtask
   // Data moves only with the clock low; g adds an 8 ns spike
   task automatic bit_out(input logic b, input logic g);
      sda_ff <= b;
      wait_q();
      scl_ff <= 1'b1;
      repeat (Q / 2) @(posedge mclk);
      glitch <= g;
      #8 glitch <= 1'b0;
      repeat (Q / 2) @(posedge mclk);
      scl_ff <= 1'b0;
      wait_q();
   endtask
   task automatic byte_out(input logic [7:0] d, input logic g,
                           output logic ack);
      for (int i = 7; i >= 0; i--)
         bit_out(d[i], g && i == 7);
      sda_ff <= 1'b1;
      wait_q();
      scl_ff <= 1'b1;
      wait_q();
      ack = ~sda_line;
      scl_ff <= 1'b0;
      wait_q();
   endtask
endmodule

// *** tb/tb_serial_eeprom_two_wire_slave.sv ***
// Bench for the two-wire EEPROM slave with a bus master model.
// Assumes a short program cycle set through WR_CYC.
module tb_serial_eeprom_two_wire_slave;
   timeunit 1ns;
   timeprecision 1ps;
   import sew_pkg::*;
   localparam int WRC = 4000;
   localparam logic [3:0] DEVT = 4'h9; // Arbitrary type code
   logic mclk = 1'b0, link_clk = 1'b0, reset_n = 1'b0;
   logic wp = 1'b0, prog_ready = 1'b1, scl_in, sda_in, sda_oe, sda_out;
   logic strap_one = 1'b1, strap_two = 1'b0;
   logic prog_valid, prog_commit, prog_busy;
   sew_prog_word_t prog_word;
   sew_prog_word_t got[$];
   int n_errors = 0, check_count = 0, n_commit = 0, cyc = 0, c_commit = 0;
   always #2.5 mclk = ~mclk;
   always #16 link_clk = ~link_clk;
   sew_slave #(.WR_CYC(WRC), .DEV_TYPE(DEVT)) uut (.mclk(mclk),
      .reset_n(reset_n), .link_clk(link_clk), .scl_in(scl_in),
      .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
      .strap_addr_bit_one(strap_one), .strap_addr_bit_two(strap_two),
      .write_protect(wp), .prog_word(prog_word), .prog_valid(prog_valid),
      .prog_ready(prog_ready), .prog_commit(prog_commit),
      .prog_busy(prog_busy));
   sew_bus_master #(.Q(50)) bus (.mclk(mclk), .sda_oe(sda_oe),
      .sda_out(sda_out), .scl_line(scl_in), .sda_line(sda_in));
   always @(posedge mclk)
   begin
      cyc++;
      if (prog_valid === 1'b1 && prog_ready === 1'b1)
         got.push_back(prog_word);
      if (prog_commit === 1'b1)
      begin
         n_commit++;
         c_commit = cyc;
      end
   end
   task automatic chk(input bit ok, input string what);
      check_count++;
      if (!ok)
      begin
         n_errors++;
         $display("[ERR] %0t %s", $time, what);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   function automatic logic [7:0] sa(input logic blk, input logic rd);
      return {DEVT, 2'b01, blk, rd};
   endfunction
   task automatic head(input logic [7:0] s, input logic [7:0] w);
      logic a;
      got.delete();
      bus.start();
      bus.byte_out(s, 1'b0, a);
      chk(a, "address not acked");
      bus.byte_out(w, 1'b0, a);
      chk(a, "word address not acked");
   endtask
   task automatic wait_commit(input int c0);
      for (int n = 0; n < 200 && n_commit == c0; n++)
         @(posedge mclk);
      chk(n_commit == c0 + 1 && prog_busy === 1'b1,
          "no commit");
   endtask
   task automatic wait_idle();
      for (int n = 0; n < 2 * WRC && prog_busy !== 1'b0; n++)
         @(posedge mclk);
      chk(cyc - c_commit inside {[WRC - 8:WRC + 8]},
          "program time");
      repeat (200) @(posedge mclk);
   endtask
   task automatic t_badaddr();
      logic a;
      logic [7:0] bad [3] = '{{DEVT ^ 4'h1, 4'h4}, {DEVT, 4'h0},
                              {DEVT, 4'hC}};
      foreach (bad[i])
      begin
         bus.start();
         bus.byte_out(bad[i], 1'b0, a);
         chk(!a, "foreign address acked");
         bus.stop();
      end
      // Restrapped device answers its new address only
      strap_one <= 1'b0;
      strap_two <= 1'b1;
      bus.start();
      bus.byte_out({DEVT, 4'h8}, 1'b0, a);
      chk(a, "restrapped address not acked");
      bus.stop();
      bus.start();
      bus.byte_out(sa(1'b0, 1'b0), 1'b0, a);
      chk(!a, "old strap address acked");
      bus.stop();
      strap_one <= 1'b1;
      strap_two <= 1'b0;
   endtask
   // Seventeen bytes wrap the page; the consumer stalls across the stop
   task automatic t_page();
      logic a;
      int c0 = n_commit;
      head(sa(1'b1, 1'b0), 8'h3E);
      for (int i = 0; i < 17; i++)
      begin
         if (i == 14)
            prog_ready <= 1'b0;
         bus.byte_out(8'h40 + 8'(i), 1'b0, a);
         chk(a, "data not acked");
      end
      bus.stop();
      repeat (300) @(posedge mclk);
      chk(n_commit == c0, "commit before drain");
      prog_ready <= 1'b1;
      wait_commit(c0);
      chk(got.size() == 17, "word count");
      foreach (got[i])
         chk(got[i] ===
             {i == 0, 1'b1, 4'h3, 4'hE + 4'(i), 8'h40 + 8'(i)}, "page word");
      bus.start();
      bus.byte_out(sa(1'b0, 1'b0), 1'b0, a);
      chk(!a, "acked while busy");
      bus.stop();
      wait_idle();
      bus.start();
      bus.byte_out(sa(1'b0, 1'b1), 1'b0, a);
      chk(a, "read address not acked");
      bus.stop();
   endtask
   task automatic t_protect();
      logic a;
      int c0 = n_commit;
      wp <= 1'b1;
      head(sa(1'b1, 1'b0), 8'h05);
      bus.byte_out(8'h77, 1'b0, a);
      chk(!a, "protected data acked");
      bus.stop();
      repeat (300) @(posedge mclk);
      chk(n_commit == c0 && got.size() == 0,
          "protected write");
      // Lower block stays writable; the byte carries a spike on SDA
      head(sa(1'b0, 1'b0), 8'h05);
      bus.byte_out(8'hC3, 1'b1, a);
      chk(a, "spike broke the frame");
      bus.stop();
      wait_commit(c0);
      chk(got.size() == 1 && got[0] === 18'h205C3, "low word");
      wp <= 1'b0;
      wait_idle();
   endtask
   // A start mid-byte restarts; a stop mid-byte after data must not program
   task automatic t_abort();
      logic a;
      int c0 = n_commit;
      head(sa(1'b0, 1'b0), 8'h20);
      bus.byte_out(8'h11, 1'b0, a);
      for (int i = 0; i < 4; i++)
         bus.bit_out(1'b1, 1'b0);
      bus.start();
      bus.byte_out(sa(1'b0, 1'b0), 1'b0, a);
      chk(a, "restart address not acked");
      bus.byte_out(8'h30, 1'b0, a);
      bus.byte_out(8'h22, 1'b0, a);
      chk(a, "restart data not acked");
      for (int i = 0; i < 4; i++)
         bus.bit_out(1'b0, 1'b0);
      bus.stop();
      repeat (300) @(posedge mclk);
      chk(n_commit == c0 && got.size() == 2, "abort wrote");
   endtask
   initial
   begin
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (40) @(posedge mclk);
      t_badaddr();
      t_page();
      t_protect();
      t_abort();
      tally_and_finish();
   end
   initial
   begin
      repeat (100000) @(posedge mclk);
      n_errors++;
      tally_and_finish();
   end
endmodule
